// [hdl/cifd_decoder.sv]
// instruction format decoder with cycle sequencer, flags and table pointer
`timescale 1ns/1ns

// Function
// - one-word instructions, four take two words
// - split word into opcode and operand fields
// - classify byte, bit, literal or control
// - destination bit picks accumulator or file
// - access bit picks access RAM or bank
// - three-bit index selects bit 0 to 7
// - file operand: 8-bit address or pointer select
// - register move carries two 12-bit addresses
// - literals are 8, 12 or 20 bits
// - table ops: none, post-inc, post-dec, pre-inc
// - branch target relative signed or absolute
// - lone second word executes as no-operation
// - single word one cycle, two if taken
// - two-word instructions take two cycles
// - instruction cycle equals four oscillator periods
// - keep carry, digit carry, zero, overflow, negative
// - recognise extended subset of eight instructions
// - mode bit selects fast shadow save/restore
// - table pointer 21 bits, latch 8 bits
module cifd_decoder (
    input  wire logic                              i_clk,
    input  wire logic                              i_sys_rst,
    input  wire logic [cifd_pkg::WORD_W-1:0]       i_word,
    input  wire logic                              i_ext_en,
    input  wire logic                              i_test_true,
    input  wire logic [cifd_pkg::FLAG_N-1:0]       i_flag_we,
    input  wire logic [cifd_pkg::FLAG_N-1:0]       i_flag_val,
    input  wire logic                              i_table_pointer_we,
    input  wire logic [cifd_pkg::TABLE_POINTER_W-1:0]     i_table_pointer_val,
    input  wire logic [cifd_pkg::TBLAT_W-1:0]      i_tbl_byte,
    output logic                                   o_cyc_en,
    output logic [1:0]                             o_phase,
    output logic                                   o_word_used,
    output logic                                   o_second_cycle,
    output cifd_pkg::cifd_dec_s                    o_dec,
    output logic [cifd_pkg::FLAG_N-1:0]            o_status,
    output logic [cifd_pkg::TABLE_POINTER_W-1:0]          o_table_pointer,
    output logic [cifd_pkg::TABLE_POINTER_W-1:0]          o_table_addr,
    output logic [cifd_pkg::TBLAT_W-1:0]           o_table_latch
);
    typedef enum logic [1:0] {ST_EXEC, ST_SECOND, ST_FLUSH} cifd_state_e;

    cifd_state_e                    state;
    cifd_state_e                    next_state;
    logic [cifd_pkg::WORD_W-1:0]    ir;
    cifd_pkg::cifd_dec_s            next_dec;

    // full decode of a first word, with the following word for two-word forms
    function automatic cifd_pkg::cifd_dec_s dec_fn(input logic [15:0] w,
                                                   input logic [15:0] s,
                                                   input logic        ext);
        cifd_pkg::cifd_dec_s r;
        r = '0;
        r.cat       = cifd_pkg::CAT_BYTE;
        r.lit_w     = cifd_pkg::LW_NONE;
        r.dest_file = w[9];
        r.use_bank  = w[8];
        r.bit_idx   = w[11:9];
        r.file_addr = w[7:0];
        r.ptr_sel   = w[5:4];
        if (w[15:12] == cifd_pkg::OP_SECOND) begin
            r.cat    = cifd_pkg::CAT_CTRL;
            r.is_nop = 1'b1;
        end else if (w[15:12] >= cifd_pkg::OP_BIT_LO && w[15:12] <= cifd_pkg::OP_BIT_HI) begin
            r.cat = cifd_pkg::CAT_BIT;
        end else if (w[15:12] == cifd_pkg::OP_MOVE) begin
            r.two_word = 1'b1;
            r.src_addr = w[11:0];
            r.dst_addr = s[11:0];
        end else if (w[15:12] == cifd_pkg::OP_BRREL) begin
            r.cat         = cifd_pkg::CAT_CTRL;
            r.br_rel      = 1'b1;
            r.flow_change = 1'b1;
            r.target      = {{9{w[10]}}, w[10:0]};
        end else if (w[15:11] == cifd_pkg::OP_BCOND) begin
            r.cat    = cifd_pkg::CAT_CTRL;
            r.br_rel = 1'b1;
            r.target = {{12{w[7]}}, w[7:0]};
        end else if (w[15:8] == cifd_pkg::OP_PTRLD) begin
            r.cat      = cifd_pkg::CAT_LIT;
            r.two_word = 1'b1;
            r.lit      = {8'h00, w[3:0], s[7:0]};
            r.lit_w    = cifd_pkg::LW_12;
        end else if (w[15:9] == cifd_pkg::OP_CALL || w[15:8] == cifd_pkg::OP_GOTO) begin
            r.cat         = cifd_pkg::CAT_CTRL;
            r.two_word    = 1'b1;
            r.br_abs      = 1'b1;
            r.flow_change = 1'b1;
            r.fast_mode   = (w[15:9] == cifd_pkg::OP_CALL) & w[8];
            r.target      = {s[11:0], w[7:0]};
            r.lit         = {s[11:0], w[7:0]};
            r.lit_w       = cifd_pkg::LW_20;
        end else if (w[15:10] == cifd_pkg::OP_EXT) begin
            r.cat      = cifd_pkg::CAT_LIT;
            r.extended = ext;
            r.is_nop   = ~ext;
        end else if (w[15:11] == cifd_pkg::OP_LIT8 || w[15:8] == cifd_pkg::OP_BANKLD) begin
            r.cat   = cifd_pkg::CAT_LIT;
            r.lit   = {12'h000, w[7:0]};
            r.lit_w = cifd_pkg::LW_8;
        end else if (w[15:8] == cifd_pkg::OP_MISC) begin
            r.cat    = cifd_pkg::CAT_CTRL;
            r.is_nop = (w == cifd_pkg::OP_NOP);
            if (w[7:3] == cifd_pkg::OP_TBL) begin
                r.tbl_op    = 1'b1;
                r.tbl_write = w[2];
                r.tbl_mode  = w[1:0];
            end else if (w[7:2] == cifd_pkg::OP_RET) begin
                r.br_abs      = 1'b1;
                r.flow_change = 1'b1;
                r.fast_mode   = w[0];
            end else if (w == cifd_pkg::OP_CALLW) begin
                r.extended    = ext;
                r.flow_change = ext;
                r.is_nop      = ~ext;
            end
        end
        return r;
    endfunction

    // sequencing decisions
    wire logic in_exec     = (state == ST_EXEC);
    // taken test or program counter change of a single-word instruction
    wire logic flush_req   = ~o_dec.two_word & (o_dec.flow_change | i_test_true);
    wire logic take_second = o_cyc_en & in_exec & o_dec.two_word;
    wire logic go_flush    = o_cyc_en & in_exec & flush_req;
    wire logic take_new    = o_cyc_en & ~take_second & ~go_flush;

    wire cifd_pkg::cifd_dec_s dec_first  = dec_fn(i_word, cifd_pkg::WORD_RST, i_ext_en);
    wire cifd_pkg::cifd_dec_s dec_second = dec_fn(ir, i_word, i_ext_en);
    wire cifd_pkg::cifd_dec_s dec_nop    = dec_fn(cifd_pkg::OP_NOP, cifd_pkg::WORD_RST, 1'b0);

    assign next_dec   = take_new ? dec_first : take_second ? dec_second :
                        go_flush ? dec_nop : o_dec;
    assign next_state = take_second ? ST_SECOND : go_flush ? ST_FLUSH :
                        take_new ? ST_EXEC : state;

    // table pointer decisions for a newly taken table instruction
    wire logic                           tbl_start = take_new & dec_first.tbl_op;
    wire logic [cifd_pkg::TABLE_POINTER_W-1:0]  ptr_inc   = o_table_pointer + 21'h0_0001;
    wire logic [cifd_pkg::TABLE_POINTER_W-1:0]  ptr_dec   = o_table_pointer - 21'h0_0001;
    logic [cifd_pkg::TABLE_POINTER_W-1:0]       next_ptr;
    always_comb begin
        case (dec_first.tbl_mode)
            cifd_pkg::TM_POSTINC: next_ptr = ptr_inc;
            cifd_pkg::TM_POSTDEC: next_ptr = ptr_dec;
            cifd_pkg::TM_PREINC:  next_ptr = ptr_inc;
            default:              next_ptr = o_table_pointer;
        endcase
    end
    wire logic [cifd_pkg::TABLE_POINTER_W-1:0] next_addr =
        (dec_first.tbl_mode == cifd_pkg::TM_PREINC) ? ptr_inc : o_table_pointer;
    wire logic latch_load = o_cyc_en & in_exec & o_dec.tbl_op & ~o_dec.tbl_write;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_phase  <= cifd_pkg::PHASE_RST;
            o_cyc_en <= 1'b0;
        end else begin
            o_phase  <= o_phase + 2'h1;
            o_cyc_en <= (o_phase == cifd_pkg::PH_BEFORE_LAST);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state          <= ST_FLUSH;
            ir             <= cifd_pkg::WORD_RST;
            o_dec          <= '0;
            o_word_used    <= 1'b0;
            o_second_cycle <= 1'b0;
        end else begin
            state          <= next_state;
            o_dec          <= next_dec;
            o_word_used    <= take_new | take_second;
            o_second_cycle <= (next_state == ST_SECOND);
            if (take_new) begin
                ir <= i_word;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_status <= cifd_pkg::FLAGS_RST;
        end else if (o_cyc_en) begin
            o_status <= (o_status & ~i_flag_we) | (i_flag_val & i_flag_we);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_table_pointer <= cifd_pkg::TABLE_POINTER_RST;
            o_table_addr    <= cifd_pkg::TABLE_POINTER_RST;
            o_table_latch   <= cifd_pkg::TBLAT_RST;
        end else begin
            if (tbl_start) begin
                o_table_pointer <= next_ptr;
                o_table_addr    <= next_addr;
            end else if (i_table_pointer_we) begin
                o_table_pointer <= i_table_pointer_val;
            end
            if (latch_load) begin
                o_table_latch <= i_tbl_byte;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_gap3;
        !o_cyc_en [*3] ##1 o_cyc_en;
    endsequence
    sequence s_second_then_new;
        (state == ST_SECOND) ##4 (state != ST_SECOND);
    endsequence

    property p_cycle_len;
        o_cyc_en |=> s_gap3;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle not four periods");

    property p_two_word;
        take_second |=> o_second_cycle ##0 s_second_then_new;
    endproperty
    a_two_word: assert property (p_two_word) else $error("two-word timing wrong");

    property p_flush;
        go_flush |=> (state == ST_FLUSH) && o_dec.is_nop && !o_word_used;
    endproperty
    a_flush: assert property (p_flush) else $error("extra cycle not a nop");

    property p_single;
        (take_new && !dec_first.two_word && !dec_first.flow_change)
            |=> (state == ST_EXEC) [*4];
    endproperty
    a_single: assert property (p_single) else $error("single word not single");

    property p_lone_second;
        (take_new && i_word[15:12] == cifd_pkg::OP_SECOND) |=> o_dec.is_nop;
    endproperty
    a_lone_second: assert property (p_lone_second) else $error("second word not nop");

    property p_dest_bank;
        take_new |=> (o_dec.dest_file == $past(i_word[9]))
                  && (o_dec.use_bank == $past(i_word[8]))
                  && (o_dec.bit_idx == $past(i_word[11:9]));
    endproperty
    a_dest_bank: assert property (p_dest_bank) else $error("operand bits wrong");

    property p_move_addr;
        (take_second && ir[15:12] == cifd_pkg::OP_MOVE)
            |=> (o_dec.dst_addr == $past(i_word[11:0])) && (o_dec.src_addr == $past(ir[11:0]));
    endproperty
    a_move_addr: assert property (p_move_addr) else $error("move addresses wrong");

    property p_postinc;
        (tbl_start && dec_first.tbl_mode == cifd_pkg::TM_POSTINC)
            |=> (o_table_pointer == $past(o_table_pointer) + 21'h0_0001)
             && (o_table_addr == $past(o_table_pointer));
    endproperty
    a_postinc: assert property (p_postinc) else $error("post-increment wrong");

    property p_flags;
        (o_cyc_en && i_flag_we[cifd_pkg::FL_Z]) |=> o_status[cifd_pkg::FL_Z] == $past(i_flag_val[cifd_pkg::FL_Z]);
    endproperty
    a_flags: assert property (p_flags) else $error("zero flag not updated");
endmodule

// [include/cifd_pkg.sv]
// constants, types and field layouts for the instruction format decoder
package cifd_pkg;
    localparam int WORD_W    = 16;
    localparam int TABLE_POINTER_W  = 21;
    localparam int TBLAT_W   = 8;
    localparam int FLAG_N    = 5;
    localparam int LIT_W     = 20;
    localparam int FADDR_W   = 12;
    localparam int PHASES    = 4;

    // phase count: the enable rises on the last oscillator period of a cycle
    localparam logic [1:0] PH_BEFORE_LAST = 2'h2;

    // reset values
    localparam logic [1:0]          PHASE_RST  = 2'h0;
    localparam logic [FLAG_N-1:0]   FLAGS_RST  = 5'h00;
    localparam logic [TABLE_POINTER_W-1:0] TABLE_POINTER_RST = 21'h0_0000;
    localparam logic [TBLAT_W-1:0]  TBLAT_RST  = 8'h00;
    localparam logic [WORD_W-1:0]   WORD_RST   = 16'h0000;

    // flag positions in the status vector
    localparam int FL_C  = 0;
    localparam int FL_DC = 1;
    localparam int FL_Z  = 2;
    localparam int FL_OV = 3;
    localparam int FL_N  = 4;

    // opcode patterns
    localparam logic [3:0]  OP_SECOND = 4'hF;
    localparam logic [3:0]  OP_BIT_LO = 4'h7;
    localparam logic [3:0]  OP_BIT_HI = 4'hB;
    localparam logic [3:0]  OP_MOVE   = 4'hC;
    localparam logic [3:0]  OP_BRREL  = 4'hD;
    localparam logic [3:0]  OP_GRP0   = 4'h0;
    localparam logic [4:0]  OP_BCOND  = 5'h1C;
    localparam logic [4:0]  OP_LIT8   = 5'h01;
    localparam logic [7:0]  OP_PTRLD  = 8'hEE;
    localparam logic [6:0]  OP_CALL   = 7'h76;
    localparam logic [7:0]  OP_GOTO   = 8'hEF;
    localparam logic [5:0]  OP_EXT    = 6'h3A;
    localparam logic [7:0]  OP_BANKLD = 8'h01;
    localparam logic [7:0]  OP_MISC   = 8'h00;
    localparam logic [4:0]  OP_TBL    = 5'h01;
    localparam logic [5:0]  OP_RET    = 6'h04;
    localparam logic [15:0] OP_CALLW  = 16'h0014;
    localparam logic [15:0] OP_NOP    = 16'h0000;

    // table pointer update modes
    localparam logic [1:0] TM_NOCHG   = 2'h0;
    localparam logic [1:0] TM_POSTINC = 2'h1;
    localparam logic [1:0] TM_POSTDEC = 2'h2;
    localparam logic [1:0] TM_PREINC  = 2'h3;

    typedef enum logic [1:0] {CAT_BYTE, CAT_BIT, CAT_LIT, CAT_CTRL} cifd_cat_e;
    typedef enum logic [1:0] {LW_NONE, LW_8, LW_12, LW_20} cifd_lw_e;

    typedef struct packed {
        cifd_cat_e          cat;
        logic               is_nop;
        logic               dest_file;
        logic               use_bank;
        logic [2:0]         bit_idx;
        logic [7:0]         file_addr;
        logic [1:0]         ptr_sel;
        logic [FADDR_W-1:0] src_addr;
        logic [FADDR_W-1:0] dst_addr;
        logic [LIT_W-1:0]   lit;
        cifd_lw_e           lit_w;
        logic               tbl_op;
        logic               tbl_write;
        logic [1:0]         tbl_mode;
        logic               br_rel;
        logic               br_abs;
        logic [LIT_W-1:0]   target;
        logic               fast_mode;
        logic               two_word;
        logic               flow_change;
        logic               extended;
    } cifd_dec_s;
endpackage

// [sim/cifd_fetch_model.sv]
// program fetch and datapath stand-in that feeds words to the decoder
`timescale 1ns/1ns
module cifd_fetch_model (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [1:0]  i_phase,
    input  wire logic        i_cyc_en,
    output logic      [15:0] o_word = 16'h0000,
    output logic             o_test_true = 1'b0,
    output logic             o_ext_en = 1'b0
);
    logic [17:0] q[$];
    logic [17:0] e;
    logic        held_tt;

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_word <= 16'h0000;
            o_test_true <= 1'b0;
            o_ext_en <= 1'b0;
            held_tt <= 1'b0;
        end else if (i_phase == 2'h2) begin
            // next word stands for the whole sampling cycle, nop when empty
            e = (q.size() > 0) ? q.pop_front() : 18'h0_0000;
            {o_ext_en, held_tt, o_word} <= e;
        end else begin
            // no stale word outside the sampling cycle
            o_word <= ~o_word;
            if (i_cyc_en) begin
                o_test_true <= held_tt;
            end
        end
    end
endmodule

// [sim/tb_cifd_decoder.sv]
// self-checking bench for the instruction format decoder
`timescale 1ns/1ns
module tb_cifd_decoder;
    localparam int K_BYTE = 0, K_BIT = 1, K_TW1 = 2, K_MOVE2 = 3, K_CALL2 = 4, K_LIT2 = 5;
    localparam int K_NOP = 6, K_BR = 7, K_RET = 8, K_TBL = 9, K_EXT = 10;
    typedef struct {int k; int used; int sec; int a; int b; int c;} cifd_exp_s;

    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [15:0] i_word;
    logic        i_ext_en;
    logic        i_test_true;
    logic [4:0]  i_flag_we = 5'h00;
    logic [4:0]  i_flag_val = 5'h00;
    logic        i_table_pointer_we = 1'b0;
    logic [20:0] i_table_pointer_val = 21'h0_0000;
    logic [7:0]  i_tbl_byte = 8'h00;
    logic        o_cyc_en;
    logic [1:0]  o_phase;
    logic        o_word_used;
    logic        o_second_cycle;
    cifd_pkg::cifd_dec_s o_dec;
    logic [4:0]  o_status;
    logic [20:0] o_table_pointer;
    logic [20:0] o_table_addr;
    logic [7:0]  o_table_latch;
    logic [31:0] rs = 32'h0000_000E;
    logic [31:0] rnd;
    int          n_errors = 0;
    int          num_checks = 0;
    int          exp_st, exp_ptr, exp_adr, exp_lat, cnt;
    bit          chk, prev_rd, tbl;
    cifd_exp_s   cur;
    cifd_exp_s   eq[$];

    cifd_decoder i_cifd_decoder (
        .i_clk, .i_sys_rst, .i_word, .i_ext_en, .i_test_true, .i_flag_we, .i_flag_val,
        .i_table_pointer_we, .i_table_pointer_val, .i_tbl_byte, .o_cyc_en, .o_phase, .o_word_used,
        .o_second_cycle, .o_dec, .o_status, .o_table_pointer, .o_table_addr, .o_table_latch
    );
    cifd_fetch_model i_cifd_fetch_model (
        .i_clk, .i_sys_rst, .i_phase(o_phase), .i_cyc_en(o_cyc_en), .o_word(i_word),
        .o_test_true(i_test_true), .o_ext_en(i_ext_en)
    );

    always #50 i_clk = ~i_clk;

    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    task automatic cmp(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic results();
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // queue one word; a taken test or single-word pc write discards the following word
    task automatic ins(input logic [15:0] w, input bit tt, input bit ext, input int k,
                       input int sec, input int a, input int b, input int c);
        i_cifd_fetch_model.q.push_back({ext, tt, w});
        eq.push_back('{k, 1, sec, a, b, c});
        if (tt) begin
            i_cifd_fetch_model.q.push_back(18'h0_0009);
            eq.push_back('{K_NOP, 0, 0, 0, 0, 0});
        end
    endtask

    task automatic gen();
        logic [31:0] r;
        logic [15:0] w;
        logic [15:0] v;
        r = xs();
        w = {4'h2 + {2'b00, r[13:12]}, r[11:0]};
        v = {4'hF, r[27:16]};
        case (r[31:28] % 10)
            0, 1: ins(w, r[20], r[21], K_BYTE, 0, w[9], w[8], w[7:0]);
            2: begin
                w[15:12] = 4'h7 + {2'b00, r[13:12]};
                ins(w, r[20], r[21], K_BIT, 0, w[11:9], w[8], w[7:0]);
            end
            3: begin
                ins({4'hC, r[11:0]}, 1'b0, r[21], K_TW1, 0, 0, 0, 0);
                ins(v, 1'b0, r[21], K_MOVE2, 1, r[11:0], v[11:0], 0);
            end
            4: begin
                w[15:8] = r[15] ? 8'hEF : {7'h76, r[14]};
                ins(w, 1'b0, r[21], K_TW1, 0, 0, 0, 0);
                ins(v, 1'b0, r[21], K_CALL2, 1, {v[11:0], w[7:0]}, w[8], !r[15]);
            end
            5: begin
                w = {10'h3B8, r[5:0]};
                v[11:8] = 4'h0;
                ins(w, 1'b0, r[21], K_TW1, 0, 0, 0, 0);
                ins(v, 1'b0, r[21], K_LIT2, 1, {w[3:0], v[7:0]}, w[5:4], 0);
            end
            6: ins({5'h1A, r[10:0]}, 1'b1, r[21], K_BR, 0, 0, 0, 0);
            7: ins({15'h0009, r[0]}, 1'b1, r[21], K_RET, 0, r[0], 0, 0);
            8: ins({13'h0001, r[2:0]}, 1'b0, r[21], K_TBL, 0, r[1:0], r[2], 0);
            default: begin
                if (r[22])
                    ins({7'h74, r[8:0]}, 1'b0, r[21], K_EXT, 0, r[21], 0, 0);
                else
                    ins(v, 1'b0, r[21], K_NOP, 0, 0, 0, 0);
            end
        endcase
    endtask

    always @(posedge i_clk) begin
        rnd = xs();
        i_flag_we <= rnd[4:0];
        i_flag_val <= rnd[9:5];
        i_tbl_byte <= rnd[17:10];
        i_table_pointer_we <= rnd[20:18] == 3'h0;
        i_table_pointer_val <= rnd[21] ? 21'h1F_FFFF : rnd[31:11];
    end

    // reference model advanced at every rising clock edge
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {exp_st, exp_ptr, exp_adr, exp_lat} = '0;
            // phase 0 after reset: the first cycle already counts one period
            cnt = 1;
            {chk, prev_rd} = '0;
        end else begin
            cnt = o_cyc_en ? 1 : cnt + 1;
            chk = 0;
            tbl = 0;
            if (o_cyc_en) begin
                exp_st = (exp_st & ~i_flag_we) | (i_flag_we & i_flag_val);
                if (prev_rd)
                    exp_lat = i_tbl_byte;
                prev_rd = 0;
                if (eq.size() > 0) begin
                    cur = eq.pop_front();
                    chk = 1;
                    tbl = cur.k == K_TBL;
                end
            end
            if (tbl) begin
                exp_adr = ((cur.a == 3) ? exp_ptr + 1 : exp_ptr) & 32'h001F_FFFF;
                exp_ptr = exp_ptr + ((cur.a == 1 || cur.a == 3) ? 1 : (cur.a == 2) ? -1 : 0);
                exp_ptr = exp_ptr & 32'h001F_FFFF;
                prev_rd = !cur.b;
            end else if (i_table_pointer_we) begin
                exp_ptr = i_table_pointer_val;
            end
        end
    end

    always @(negedge i_clk) begin
        if (!i_sys_rst) begin
            cmp("status", o_status, exp_st);
            cmp("table_pointer", o_table_pointer, exp_ptr);
            cmp("table_addr", o_table_addr, exp_adr);
            cmp("table_latch", o_table_latch, exp_lat);
            if (o_cyc_en) begin
                cmp("cycle_len", cnt, 4);
                cmp("phase", o_phase, 3);
            end
            if (chk) begin
                cmp("word_used", o_word_used, cur.used);
                cmp("second_cycle", o_second_cycle, cur.sec);
                case (cur.k)
                    K_BYTE: begin
                        cmp("cat", o_dec.cat, cifd_pkg::CAT_BYTE);
                        cmp("dest_file", o_dec.dest_file, cur.a);
                        cmp("use_bank", o_dec.use_bank, cur.b);
                        cmp("file_addr", o_dec.file_addr, cur.c);
                    end
                    K_BIT: begin
                        cmp("cat", o_dec.cat, cifd_pkg::CAT_BIT);
                        cmp("bit_idx", o_dec.bit_idx, cur.a);
                        cmp("use_bank", o_dec.use_bank, cur.b);
                        cmp("file_addr", o_dec.file_addr, cur.c);
                    end
                    K_TW1: cmp("two_word", o_dec.two_word, 1);
                    K_MOVE2: begin
                        cmp("src_addr", o_dec.src_addr, cur.a);
                        cmp("dst_addr", o_dec.dst_addr, cur.b);
                    end
                    K_CALL2: begin
                        cmp("target", o_dec.target, cur.a);
                        if (cur.c)
                            cmp("fast_mode", o_dec.fast_mode, cur.b);
                    end
                    K_LIT2: begin
                        cmp("lit", o_dec.lit, cur.a);
                        cmp("ptr_sel", o_dec.ptr_sel, cur.b);
                    end
                    K_NOP: cmp("is_nop", o_dec.is_nop, 1);
                    K_BR: begin
                        cmp("br_rel", o_dec.br_rel, 1);
                        cmp("flow_change", o_dec.flow_change, 1);
                    end
                    K_RET: begin
                        cmp("cat", o_dec.cat, cifd_pkg::CAT_CTRL);
                        cmp("fast_mode", o_dec.fast_mode, cur.a);
                    end
                    K_TBL: begin
                        cmp("tbl_mode", o_dec.tbl_mode, cur.a);
                        cmp("tbl_write", o_dec.tbl_write, cur.b);
                    end
                    default: begin
                        cmp("extended", o_dec.extended, cur.a);
                        cmp("is_nop", o_dec.is_nop, !cur.a);
                    end
                endcase
            end
        end
    end

    initial begin
        repeat (80) gen();
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int i = 0; i < 4000 && eq.size() > 0; i++) @(posedge i_clk);
        repeat (4) @(posedge i_clk);
        if (eq.size() > 0)
            n_errors++;
        results();
    end

    initial begin
        #1_000_000;
        n_errors++;
        results();
    end
endmodule
